// file: design/rps_pkg.sv
// Package: register map, field layout, reset values and carriers of the remap crossbar
package rps_pkg;
    localparam int SEL_W = 6;
    localparam int NUM_IN_REGS = 19;
    localparam int NUM_IN_FUNCS = 38;
    localparam int NUM_OUT_CODES = 32;
    localparam int NUM_IO_PINS = 29;
    localparam int NUM_PINS = 33;
    localparam int NUM_OUT_REGS = 15;
    // Field positions inside a select register
    localparam int FLD_LO_POS = 0;
    localparam int FLD_HI_POS = 8;
    // Reset values
    localparam logic [5:0] IN_SEL_RESET = 6'h3f;
    localparam logic [5:0] OUT_SEL_RESET = 6'h00;
    localparam logic [5:0] OUT_CODE_NONE = 6'h00;
    localparam logic [5:0] OUT_CODE_RSVD = 6'h16;
    // Byte addresses
    localparam logic [11:0] ADDR_IN_BASE = 12'h000;
    localparam logic [11:0] ADDR_OUT_BASE = 12'h080;
    localparam logic [11:0] ADDR_OSC_CTRL = 12'h100;
    localparam logic [11:0] ADDR_STATUS = 12'h104;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
    localparam int LOCK_BIT_POS = 6;
    // Documented register numbers of the input map registers, in slot order
    localparam int IN_REG_NUM [NUM_IN_REGS] = '{0, 1, 2, 3, 5, 6, 7, 8, 11, 12,
                                                18, 19, 20, 21, 22, 23, 25, 28, 29};

    typedef enum logic [1:0] {
        RPS_IDLE,
        RPS_KEY1_SEEN,
        RPS_ARMED
    } rps_unlock_e;

    typedef struct packed {
        logic [NUM_PINS-1:0] level;
        logic [NUM_PINS-1:0] analog;
    } rps_pad_in_s;

    typedef struct packed {
        logic [NUM_IO_PINS-1:0] remap_drive;
        logic [NUM_IO_PINS-1:0] remap_data;
    } rps_pad_out_s;
endpackage

// file: design/rps_remap_crossbar.sv
// Remappable pin crossbar: APB registers, lock sequence, shadow monitor, routing
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module rps_remap_crossbar
    import rps_pkg::*;
#(
    parameter int IMPL_IO_PINS = NUM_IO_PINS,
    parameter int IMPL_IN_ONLY_PINS = NUM_PINS - NUM_IO_PINS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_OUT_CODES-1:0] periph_out,
    output logic [NUM_IN_FUNCS-1:0] periph_in,
    input wire rps_pad_in_s pad_in,
    output rps_pad_out_s pad_out,
    input wire logic [NUM_IO_PINS-1:0] special_drive,
    input wire logic [NUM_IO_PINS-1:0] special_data,
    output logic config_mismatch,
    output logic map_write_lock,
    input wire logic shadow_upset
);
    initial begin
        if (IMPL_IO_PINS < 1 || IMPL_IO_PINS > NUM_IO_PINS ||
            IMPL_IN_ONLY_PINS < 0 || IMPL_IN_ONLY_PINS > NUM_PINS - NUM_IO_PINS)
            $error("rps_remap_crossbar: unsupported pin count");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_meta_q, pin_meta_d, pin_sync_q, pin_sync_d;
    logic [NUM_PINS-1:0] ana_meta_q, ana_meta_d, ana_sync_q, ana_sync_d;

    always_comb begin
        pin_meta_d = pad_in.level;
        pin_sync_d = pin_meta_q;
        ana_meta_d = pad_in.analog;
        ana_sync_d = ana_meta_q;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            ana_meta_q <= '1;
            ana_sync_q <= '1;
        end else begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
            ana_meta_q <= ana_meta_d;
            ana_sync_q <= ana_sync_d;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic wr_acc, rd_acc;
    logic [5:0] word_idx;
    logic in_hit, out_hit, osc_hit, stat_hit;
    logic [4:0] in_slot, out_slot;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;

    always_comb begin
        word_idx = paddr[7:2];
        in_slot = '0;
        out_slot = word_idx[4:0];
        in_hit = 1'b0;
        for (int i = 0; i < NUM_IN_REGS; i++) begin
            if (paddr[11:7] == ADDR_IN_BASE[11:7] && paddr[1:0] == 2'b00 &&
                int'(paddr[6:2]) == IN_REG_NUM[i]) begin
                in_hit = 1'b1;
                in_slot = 5'(i);
            end
        end
        out_hit = paddr[11:7] == ADDR_OUT_BASE[11:7] && paddr[1:0] == 2'b00 &&
                  int'(paddr[6:2]) < NUM_OUT_REGS;
        osc_hit = paddr == ADDR_OSC_CTRL;
        stat_hit = paddr == ADDR_STATUS;
    end

    // ------------------------------------------------------------
    // Lock sequence
    // ------------------------------------------------------------
    rps_unlock_e unlock_q, unlock_d;
    logic lock_q, lock_d;

    always_comb begin
        unlock_d = unlock_q;
        lock_d = lock_q;
        if (wr_acc && osc_hit) begin
            unique case (unlock_q)
                RPS_IDLE: begin
                    unlock_d = (pwdata[7:0] == UNLOCK_KEY1) ? RPS_KEY1_SEEN : RPS_IDLE;
                end
                RPS_KEY1_SEEN: begin
                    // Only the two keys back to back arm the update
                    if (pwdata[7:0] == UNLOCK_KEY2)
                        unlock_d = RPS_ARMED;
                    else if (pwdata[7:0] == UNLOCK_KEY1)
                        unlock_d = RPS_KEY1_SEEN;
                    else
                        unlock_d = RPS_IDLE;
                end
                RPS_ARMED: begin
                    lock_d = pwdata[LOCK_BIT_POS];
                    unlock_d = RPS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            unlock_q <= RPS_IDLE;
            lock_q <= 1'b0;
        end else begin
            unlock_q <= unlock_d;
            lock_q <= lock_d;
        end
    end
    assign map_write_lock = lock_q;

    // ------------------------------------------------------------
    // Select registers and shadows
    // ------------------------------------------------------------
    logic [5:0] in_sel_q [2*NUM_IN_REGS];
    logic [5:0] in_sel_d [2*NUM_IN_REGS];
    logic [5:0] out_sel_q [2*NUM_OUT_REGS];
    logic [5:0] out_sel_d [2*NUM_OUT_REGS];
    logic [5:0] in_shd_q [2*NUM_IN_REGS];
    logic [5:0] out_shd_q [2*NUM_OUT_REGS];
    logic mismatch_q, mismatch_d;
    logic differ;

    always_comb begin
        in_sel_d = in_sel_q;
        out_sel_d = out_sel_q;
        // Locked writes are accepted on the bus but dropped here
        if (wr_acc && !lock_q && in_hit) begin
            in_sel_d[2*in_slot] = pwdata[FLD_LO_POS +: SEL_W];
            in_sel_d[2*in_slot+1] = pwdata[FLD_HI_POS +: SEL_W];
        end
        if (wr_acc && !lock_q && out_hit) begin
            // Fields of unimplemented pins stay zero
            if (2*int'(out_slot) < IMPL_IO_PINS)
                out_sel_d[2*out_slot] = pwdata[FLD_LO_POS +: SEL_W];
            if (2*int'(out_slot)+1 < IMPL_IO_PINS)
                out_sel_d[2*out_slot+1] = pwdata[FLD_HI_POS +: SEL_W];
        end
        differ = shadow_upset;
        for (int i = 0; i < 2*NUM_IN_REGS; i++)
            differ = differ || (in_sel_q[i] != in_shd_q[i]);
        for (int i = 0; i < 2*NUM_OUT_REGS; i++)
            differ = differ || (out_sel_q[i] != out_shd_q[i]);
        // Sticky until reset, so a one-cycle upset cannot slip past software
        mismatch_d = mismatch_q || differ;
    end

    // Shadows follow only legal writes, so any other change shows as a difference
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < 2*NUM_IN_REGS; i++) begin
                in_sel_q[i] <= IN_SEL_RESET;
                in_shd_q[i] <= IN_SEL_RESET;
            end
            for (int i = 0; i < 2*NUM_OUT_REGS; i++) begin
                out_sel_q[i] <= OUT_SEL_RESET;
                out_shd_q[i] <= OUT_SEL_RESET;
            end
            mismatch_q <= 1'b0;
        end else begin
            in_sel_q <= in_sel_d;
            in_shd_q <= in_sel_d;
            out_sel_q <= out_sel_d;
            out_shd_q <= out_sel_d;
            mismatch_q <= mismatch_d;
        end
    end
    assign config_mismatch = mismatch_q;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        prdata = '0;
        if (rd_acc && in_hit) begin
            prdata[FLD_LO_POS +: SEL_W] = in_sel_q[2*in_slot];
            prdata[FLD_HI_POS +: SEL_W] = in_sel_q[2*in_slot+1];
        end else if (rd_acc && out_hit) begin
            prdata[FLD_LO_POS +: SEL_W] = out_sel_q[2*out_slot];
            prdata[FLD_HI_POS +: SEL_W] = out_sel_q[2*out_slot+1];
        end else if (rd_acc && osc_hit) begin
            prdata[LOCK_BIT_POS] = lock_q;
        end else if (rd_acc && stat_hit) begin
            prdata[0] = mismatch_q;
            prdata[2:1] = unlock_q;
        end
    end

    // ------------------------------------------------------------
    // Input routing: one mux per peripheral input, fan-in free
    // ------------------------------------------------------------
    // Compare trigger 1 is slot 0 low, irq 1 slot 0 high
    // spi1 data/clock slot 12, spi1 select slot 13 low
    // spi2 select slot 15 low, timer clock slot 15 high
    logic [NUM_PINS-1:0] pin_digital;
    logic [NUM_PINS-1:0] pin_impl;
    assign pin_digital = pin_sync_q & ~ana_sync_q;

    always_comb begin
        for (int p = 0; p < NUM_PINS; p++)
            pin_impl[p] = (p < IMPL_IO_PINS) ||
                          (p >= NUM_IO_PINS && p < NUM_IO_PINS + IMPL_IN_ONLY_PINS);
    end

    logic [NUM_IN_FUNCS-1:0] periph_in_q, periph_in_d;
    always_comb begin
        for (int f = 0; f < NUM_IN_FUNCS; f++) begin
            // Out-of-range codes read low, which is how reset ties inputs off
            if (int'(in_sel_q[f]) < NUM_PINS && pin_impl[in_sel_q[f]])
                periph_in_d[f] = pin_digital[in_sel_q[f]];
            else
                periph_in_d[f] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset)
            periph_in_q <= '0;
        else
            periph_in_q <= periph_in_d;
    end
    assign periph_in = periph_in_q;

    // ------------------------------------------------------------
    // Output routing per pin, with priority
    // ------------------------------------------------------------
    // The pad merges port and parallel master drive below remap_drive
    // Input maps feed no term here, so the buffer is never claimed
    rps_pad_out_s pad_out_q, pad_out_d;
    always_comb begin
        pad_out_d = '0;
        for (int p = 0; p < NUM_IO_PINS; p++) begin
            if (special_drive[p]) begin
                pad_out_d.remap_drive[p] = 1'b1;
                pad_out_d.remap_data[p] = special_data[p];
            end else if (out_sel_q[p] != OUT_CODE_NONE && out_sel_q[p] != OUT_CODE_RSVD &&
                         int'(out_sel_q[p]) < NUM_OUT_CODES) begin
                // Code 3,4 uart1, 7..9 spi1 by periph_out index
                pad_out_d.remap_drive[p] = 1'b1;
                pad_out_d.remap_data[p] = periph_out[out_sel_q[p][4:0]];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset)
            pad_out_q <= '0;
        else
            pad_out_q <= pad_out_d;
    end
    assign pad_out = pad_out_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_locked_write_held: assert property (@(posedge ref_clk) disable iff (reset)
        wr_acc && lock_q && in_hit |=> in_sel_q[2*$past(in_slot)] == $past(in_sel_q[2*in_slot]))
        else $error("locked write changed an input map");
    chk_write_takes: assert property (@(posedge ref_clk) disable iff (reset)
        wr_acc && !lock_q && in_hit |=> in_sel_q[2*$past(in_slot)] == $past(pwdata[5:0]))
        else $error("unlocked write not applied next cycle");
    chk_null_code_off: assert property (@(posedge ref_clk) disable iff (reset)
        out_sel_q[0] == OUT_CODE_NONE && !special_drive[0] |=> !pad_out.remap_drive[0])
        else $error("null output code drove a pin");
    chk_special_wins: assert property (@(posedge ref_clk) disable iff (reset)
        special_drive[2] |=> pad_out.remap_drive[2] && pad_out.remap_data[2] == $past(special_data[2]))
        else $error("special output lost priority");
    chk_uart_code: assert property (@(posedge ref_clk) disable iff (reset)
        out_sel_q[3] == 6'h03 && !special_drive[3] |=> pad_out.remap_data[3] == $past(periph_out[3]))
        else $error("code 3 did not route uart1 transmit");
    chk_analog_blocks: assert property (@(posedge ref_clk) disable iff (reset)
        ana_sync_q[in_sel_q[0] % NUM_PINS] && in_sel_q[0] < 6'h21 |=> !periph_in[0])
        else $error("analog pin reached a remapped input");
    chk_unlock_seq: assert property (@(posedge ref_clk) disable iff (reset)
        $changed(lock_q) |-> $past(unlock_q) == RPS_ARMED)
        else $error("lock changed without unlock keys");
    chk_mismatch_flag: assert property (@(posedge ref_clk) disable iff (reset)
        shadow_upset |=> config_mismatch)
        else $error("shadow difference not flagged");
    cov_unlock: cover property (@(posedge ref_clk) unlock_q == RPS_ARMED);
    cov_fanout: cover property (@(posedge ref_clk) out_sel_q[0] != 0 && out_sel_q[0] == out_sel_q[1]);
    cov_locked_wr: cover property (@(posedge ref_clk) wr_acc && lock_q && out_hit);
endmodule

// file: tb/rps_far_model.sv
// Far-side model: peripheral outputs and pad levels seen by the crossbar
`timescale 1ns/1ps
module rps_far_model
    import rps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [NUM_PINS-1:0] pin_lvl,
    input wire logic [NUM_PINS-1:0] pin_ana,
    input wire logic [NUM_OUT_CODES-1:0] per_val,
    input wire rps_pad_out_s pad_out,
    output rps_pad_in_s pad_in,
    output logic [NUM_OUT_CODES-1:0] periph_out
);
    logic [NUM_PINS-1:0] lvl_d;

    always_comb begin
        lvl_d = pin_lvl;
        for (int i = 0; i < NUM_IO_PINS; i++) begin
            // Pad follows the crossbar once it owns the pin
            if (pad_out.remap_drive[i]) begin
                lvl_d[i] = pad_out.remap_data[i];
            end
        end
    end

    // Peripherals and pads change just after the clock, like real logic
    always_ff @(posedge ref_clk) begin
        pad_in.level <= lvl_d;
        pad_in.analog <= pin_ana;
        periph_out <= per_val;
    end
endmodule

// file: tb/remappable_pin_select_tb_top.sv
// Testbench of the remap crossbar: APB setup, routing tables, lock and monitor
`timescale 1ns/1ps
module remappable_pin_select_tb_top
    import rps_pkg::*;
;
    typedef struct {int n; int k; logic [31:0] wd; logic [31:0] rd;} rps_row_s;
    logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err_s, mism, lock, upset = 1'b0, on;
    logic [NUM_OUT_CODES-1:0] periph_out, per_val = '0;
    logic [NUM_IN_FUNCS-1:0] periph_in;
    logic [NUM_PINS-1:0] pin_lvl = '1, pin_ana = '0, pat = 33'h0_a5c3_9e71, pv;
    logic [NUM_IO_PINS-1:0] sp_drv = '0, sp_dat = '0;
    logic [5:0] c, lo, hi;
    rps_pad_in_s pad_in;
    rps_pad_out_s pad_out;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    rps_row_s rows[5] = '{'{0, 0, 32'hffff_e0c5, 32'h0000_2005},
                          '{20, 12, 32'h0000_1c00, 32'h0000_1c00},
                          '{21, 13, 32'h0000_3f1f, 32'h0000_3f1f},
                          '{23, 15, 32'h0000_0111, 32'h0000_0111},
                          '{18, 10, 32'h0000_0303, 32'h0000_0303}};
    logic [5:0] codes[7] = '{6'h00, 6'h03, 6'h04, 6'h07, 6'h08, 6'h09, 6'h16};

    rps_remap_crossbar dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_out(periph_out),
        .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out),
        .special_drive(sp_drv), .special_data(sp_dat), .config_mismatch(mism),
        .map_write_lock(lock), .shadow_upset(upset));

    rps_far_model far (.ref_clk(ref_clk), .pin_lvl(pin_lvl), .pin_ana(pin_ana),
        .per_val(per_val), .pad_out(pad_out), .pad_in(pad_in), .periph_out(periph_out));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One idle cycle before each setup keeps every driver write unique per edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        r = prdata;
        err_s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic expb(input logic [NUM_PINS-1:0] p, input logic [5:0] s);
        return (s < NUM_PINS) ? p[s] : 1'b0;
    endfunction

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, 12'h000, 32'h0, rd);
        check(rd, 32'h0000_3f3f);
        check(periph_in[31:0], 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, 12'(rows[i].n * 4), rows[i].wd, rd);
            apb(1'b0, 12'(rows[i].n * 4), 32'h0, rd);
            check(rd, rows[i].rd);
            lo = rows[i].wd[5:0];
            hi = rows[i].wd[13:8];
            for (int p = 0; p < 2; p++) begin
                pv = (p == 0) ? pat : ~pat;
                pin_lvl <= pv;
                repeat (5) @(posedge ref_clk);
                check({30'h0, periph_in[2*rows[i].k+1], periph_in[2*rows[i].k]},
                      {30'h0, expb(pv, hi), expb(pv, lo)});
            end
        end
        check({3'h0, pad_out.remap_drive}, 32'h0);
        pin_lvl <= '1;
        pin_ana <= 33'h0_0000_0020;
        repeat (5) @(posedge ref_clk);
        check({30'h0, periph_in[1:0]}, 32'h2);
        pin_ana <= '0;
        foreach (codes[i]) begin
            c = codes[i];
            on = (c != OUT_CODE_NONE) && (c != OUT_CODE_RSVD);
            apb(1'b1, 12'h084, {18'h0, c, 2'h0, c}, rd);
            apb(1'b0, 12'h084, 32'h0, rd);
            check(rd, {18'h0, c, 2'h0, c});
            for (int v = 0; v < 2; v++) begin
                per_val <= (v == 0) ? (32'h1 << c) : ~(32'h1 << c);
                repeat (4) @(posedge ref_clk);
                check({28'h0, pad_out.remap_drive[3:2],
                       pad_out.remap_data[3:2] & pad_out.remap_drive[3:2]},
                      {28'h0, {2{on}}, {2{on && v == 0}}});
            end
        end
        // ------------------------------------------------------------
        // Awkward cases: override, loopback, holes, lock, monitor
        // ------------------------------------------------------------
        apb(1'b1, 12'h084, 32'h0000_0303, rd);
        per_val <= 32'h0000_0008;
        pin_lvl <= '0;
        sp_drv[2] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check({28'h0, pad_out.remap_drive[3:2], pad_out.remap_data[3:2]}, 32'he);
        sp_drv[2] <= 1'b0;
        apb(1'b1, 12'h000, 32'h0000_0002, rd);
        repeat (6) @(posedge ref_clk);
        check({31'h0, periph_in[0]}, 32'h1);
        apb(1'b0, 12'h010, 32'h0, rd);
        check(rd, 32'h0);
        apb(1'b1, ADDR_OSC_CTRL, 32'h46, rd);
        apb(1'b1, ADDR_OSC_CTRL, 32'h57, rd);
        apb(1'b1, ADDR_OSC_CTRL, 32'h40, rd);
        @(posedge ref_clk);
        check({31'h0, lock}, 32'h1);
        apb(1'b1, 12'h000, 32'h0000_0707, rd);
        check({31'h0, err_s}, 32'h0);
        apb(1'b0, 12'h000, 32'h0, rd);
        check(rd, 32'h0000_0002);
        apb(1'b1, ADDR_OSC_CTRL, 32'h46, rd);
        apb(1'b1, ADDR_OSC_CTRL, 32'h00, rd);
        apb(1'b1, ADDR_OSC_CTRL, 32'h00, rd);
        @(posedge ref_clk);
        check({31'h0, lock}, 32'h1);
        apb(1'b1, ADDR_OSC_CTRL, 32'h46, rd);
        apb(1'b1, ADDR_OSC_CTRL, 32'h57, rd);
        apb(1'b1, ADDR_OSC_CTRL, 32'h00, rd);
        @(posedge ref_clk);
        check({31'h0, lock}, 32'h0);
        upset <= 1'b1;
        @(posedge ref_clk);
        upset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check({31'h0, mism}, 32'h1);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, 12'h084, 32'h0, rd);
        check(rd, 32'h0);
        check({30'h0, mism, lock}, 32'h0);
        wrap_up();
    end
endmodule
